// ==== wdog_cfg.svh ====
// Constants of the watchdog block: register map, fields, reset values, timing.
// Assumes a 100 MHz system clock and a 16-bit AXI4-Lite byte address.
// Behaviour
// - Counter ticks from its own free-running oscillator, independent of the main clock; here u_rcOsc divides sys_clk instead.
// - Counting continues while the core sleeps, so time-outs still happen.
// - Time-out while running raises a full device reset pulse.
// - Time-out while sleeping wakes the device instead of resetting it.
// - Every time-out clears the active-low timeout flag.
// - Enable fuse at zero keeps the watchdog disabled for good.
// - One postscaler shared with the timer zero path, set by option control.
// - Clear and sleep instructions restart counter and postscaler when assigned to watchdog.
// - Clear instruction zeroes the postscaler count when assigned to watchdog, but keeps its assignment bit.
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH

// Register indices as printed; byte address is four times the index
`define WDOG_IDX_OPTION 16'h0081
`define WDOG_IDX_CFGWORD 16'h2007
`define WDOG_ADDR_OPTION 16'h0204
`define WDOG_ADDR_CFGWORD 16'h801C

// Block-local registers
`define WDOG_ADDR_CTRL 16'h0000
`define WDOG_ADDR_STATUS 16'h0004
`define WDOG_ADDR_INT_STAT 16'h0008
`define WDOG_ADDR_INT_EN 16'h000C
`define WDOG_ADDR_INT_CLR 16'h0010

// Field positions
`define WDOG_OPT_ASSIGN_BIT 3
`define WDOG_OPT_RATIO_MSB 2
`define WDOG_OPT_RATIO_LSB 0
`define WDOG_CFG_FUSE_BIT 2
`define WDOG_CTRL_CLEAR_BIT 0
`define WDOG_CTRL_SLEEP_BIT 1
`define WDOG_INT_RESET_BIT 0
`define WDOG_INT_WAKE_BIT 1

// Reset values
`define WDOG_OPTION_RST 8'hFF
`define WDOG_CFG_RST 8'hFF

// AXI responses
`define WDOG_RESP_OKAY 2'h0
`define WDOG_RESP_SLVERR 2'h2

// Timing: oscillator period and its cycle count at the system rate
`define WDOG_SYS_PERIOD_NS 10
`define WDOG_RC_PERIOD_NS 1000
`define WDOG_RC_DIV_CYC ((`WDOG_RC_PERIOD_NS + `WDOG_SYS_PERIOD_NS - 1) / `WDOG_SYS_PERIOD_NS)

`endif

// ==== wdog_pkg.sv ====
// Types shared by the watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package wdog_pkg;
    typedef enum logic {
        WDOG_RUN,
        WDOG_SLEEP
    } wdog_pwr_t;
endpackage : wdog_pkg
`default_nettype wire

// ==== wdog_divcnt.sv ====
// Wrapping up-counter with synchronous clear and a run-time terminal value.
// Assumes inc and clr are synchronous to sys_clk; clr wins over inc.
`default_nettype none
module wdog_divcnt #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic inc,
    input wire logic [W-1:0] lim,
    output logic wrap
);
    logic [W-1:0] cnt_q;

    assign wrap = inc && !clr && (cnt_q >= lim);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (inc) begin
            cnt_q <= (cnt_q >= lim) ? '0 : W'(cnt_q + 1'b1);
        end
    end
endmodule : wdog_divcnt
`default_nettype wire

// ==== wdog_top.sv ====
// Watchdog with shared postscaler, AXI4-Lite register slave and interrupt.
// Assumes instruction strobes are one-cycle pulses synchronous to sys_clk.
//
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
`include "wdog_cfg.svh"
module wdog_top
    import wdog_pkg::*;
#(
    parameter int RcDivCyc = `WDOG_RC_DIV_CYC,
    parameter int BaseW = 8,
    parameter int AddrW = 16
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clearInstrIn,
    input wire logic sleepInstrIn,
    input wire logic wakeOtherIn,
    input wire logic timer0ClkTickIn,
    input wire logic [7:0] cfgWordIn,
    input wire logic [AddrW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AddrW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic deviceResetOut,
    output logic wakeUpOut,
    output logic sleepModeOut,
    output logic timeoutFlagNOut,
    output logic timer0TickOut,
    output logic irqOut
);
    localparam int RcW = $clog2(RcDivCyc + 1);

    // Bus state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic awHave_q;
    logic wHave_q;
    logic [AddrW-1:0] awAddr_q;
    logic [7:0] wData_q;
    logic wLane_q;

    // Block state
    logic cfgLoaded_q;
    logic [7:0] cfgWord_q;
    logic [7:0] option_q;
    logic [7:0] optionPrev_q;
    wdog_pwr_t pwr_q;
    logic deviceReset_q;
    logic wakeUp_q;
    logic timeoutFlagN_q;
    logic timer0Tick_q;
    logic [1:0] intStat_q;
    logic [1:0] intEn_q;
    logic irq_q;

    logic doWr;
    logic wrLow;
    logic clrCmd;
    logic sleepCmd;
    logic restart;
    logic wdogOn;
    logic prescalerAssignSel;
    logic [2:0] prescaleRatio;
    logic [7:0] psLim;
    logic rcTick;
    logic baseWrap;
    logic psInc;
    logic psClr;
    logic psWrap;
    logic timeout;
    logic [1:0] intEvt;
    logic [31:0] rdMux;
    logic rdOk;
    logic wrOk;

    // Write path: address and data may arrive in either order
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awready_q <= 1'b0;
            awHave_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awready_q && s_axi_awvalid) begin
            awready_q <= 1'b0;
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWr) begin
            awHave_q <= 1'b0;
        end else if (!awHave_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wready_q <= 1'b0;
            wHave_q <= 1'b0;
            wData_q <= 8'h00;
            wLane_q <= 1'b0;
        end else if (wready_q && s_axi_wvalid) begin
            wready_q <= 1'b0;
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
        end else if (doWr) begin
            wHave_q <= 1'b0;
        end else if (!wHave_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    assign doWr = awHave_q && wHave_q && !bvalid_q;
    // Registers are one byte wide; only lane 0 carries them
    assign wrLow = doWr && wLane_q;

    always_comb begin
        case (awAddr_q)
            `WDOG_ADDR_CTRL,
            `WDOG_ADDR_STATUS,
            `WDOG_ADDR_INT_STAT,
            `WDOG_ADDR_INT_EN,
            `WDOG_ADDR_INT_CLR,
            `WDOG_ADDR_OPTION,
            `WDOG_ADDR_CFGWORD: wrOk = 1'b1;
            default: wrOk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `WDOG_RESP_OKAY;
        end else if (doWr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrOk ? `WDOG_RESP_OKAY : `WDOG_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read path: one read in flight, answered the cycle after the address
    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        case (s_axi_araddr)
            `WDOG_ADDR_CTRL: rdMux = 32'h0000_0000;
            `WDOG_ADDR_STATUS: rdMux = {30'h0000_0000, pwr_q == WDOG_SLEEP, timeoutFlagN_q};
            `WDOG_ADDR_INT_STAT: rdMux = {30'h0000_0000, intStat_q};
            `WDOG_ADDR_INT_EN: rdMux = {30'h0000_0000, intEn_q};
            `WDOG_ADDR_INT_CLR: rdMux = 32'h0000_0000;
            `WDOG_ADDR_OPTION: rdMux = {24'h00_0000, option_q};
            `WDOG_ADDR_CFGWORD: rdMux = {24'h00_0000, cfgWord_q};
            default: rdOk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `WDOG_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= rdOk ? `WDOG_RESP_OKAY : `WDOG_RESP_SLVERR;
            rdata_q <= rdMux;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Fuse word is a strap, caught once on the first edge after release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfgLoaded_q <= 1'b0;
            cfgWord_q <= `WDOG_CFG_RST;
        end else if (!cfgLoaded_q) begin
            cfgLoaded_q <= 1'b1;
            cfgWord_q <= cfgWordIn;
        end
    end

    // No register can revive a watchdog whose fuse is zero
    assign wdogOn = cfgLoaded_q && cfgWord_q[`WDOG_CFG_FUSE_BIT];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            option_q <= `WDOG_OPTION_RST;
            optionPrev_q <= `WDOG_OPTION_RST;
        end else begin
            optionPrev_q <= option_q;
            if (wrLow && awAddr_q == `WDOG_ADDR_OPTION) begin
                option_q <= wData_q;
            end
        end
    end

    assign prescalerAssignSel = option_q[`WDOG_OPT_ASSIGN_BIT];
    assign prescaleRatio = option_q[`WDOG_OPT_RATIO_MSB:`WDOG_OPT_RATIO_LSB];

    // Instruction strobes from the core or from the control register
    assign clrCmd = clearInstrIn
        || (wrLow && awAddr_q == `WDOG_ADDR_CTRL && wData_q[`WDOG_CTRL_CLEAR_BIT]);
    assign sleepCmd = sleepInstrIn
        || (wrLow && awAddr_q == `WDOG_ADDR_CTRL && wData_q[`WDOG_CTRL_SLEEP_BIT]);
    assign restart = clrCmd || sleepCmd;

    // Private time base: free-running and never gated by sleep
    wdog_divcnt #(
        .W(RcW)
    ) u_rcOsc (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clr(1'b0),
        .inc(1'b1),
        .lim(RcW'(RcDivCyc - 1)),
        .wrap(rcTick)
    );

    wdog_divcnt #(
        .W(BaseW)
    ) u_watchdogCounter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clr(restart || !wdogOn),
        .inc(rcTick && wdogOn),
        .lim({BaseW{1'b1}}),
        .wrap(baseWrap)
    );

    // Assigned: 1:2^ratio on time-outs; else 1:2^(ratio+1) on timer zero ticks
    assign psLim = prescalerAssignSel
        ? 8'((9'h001 << prescaleRatio) - 9'h001)
        : 8'((9'h002 << prescaleRatio) - 9'h001);
    assign psInc = prescalerAssignSel ? baseWrap : timer0ClkTickIn;
    // Clearing only zeroes the count; the assignment bit is never touched here
    assign psClr = (restart && prescalerAssignSel)
        || (optionPrev_q[`WDOG_OPT_ASSIGN_BIT] != prescalerAssignSel);

    wdog_divcnt #(
        .W(8)
    ) u_postscaler (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clr(psClr),
        .inc(psInc),
        .lim(psLim),
        .wrap(psWrap)
    );

    // A restart in the same cycle cancels the pending time-out
    assign timeout = wdogOn && !restart
        && (prescalerAssignSel ? psWrap : baseWrap);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timer0Tick_q <= 1'b0;
        end else begin
            timer0Tick_q <= prescalerAssignSel ? timer0ClkTickIn : psWrap;
        end
    end

    // Power state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_q <= WDOG_RUN;
        end else begin
            case (pwr_q)
                WDOG_RUN: begin
                    if (sleepCmd) begin
                        pwr_q <= WDOG_SLEEP;
                    end
                end
                WDOG_SLEEP: begin
                    if (timeout || wakeOtherIn) begin
                        pwr_q <= WDOG_RUN;
                    end
                end
                default: pwr_q <= WDOG_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            deviceReset_q <= 1'b0;
            wakeUp_q <= 1'b0;
        end else begin
            deviceReset_q <= timeout && pwr_q == WDOG_RUN;
            wakeUp_q <= timeout && pwr_q == WDOG_SLEEP;
        end
    end

    // Flag survives the reset it causes; the time-out wins over a set
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timeoutFlagN_q <= 1'b1;
        end else if (timeout) begin
            timeoutFlagN_q <= 1'b0;
        end else if (restart) begin
            timeoutFlagN_q <= 1'b1;
        end
    end

    // Interrupt status: sticky, set beats clear
    assign intEvt = {timeout && pwr_q == WDOG_SLEEP, timeout && pwr_q == WDOG_RUN};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intStat_q <= 2'h0;
        end else if (wrLow && awAddr_q == `WDOG_ADDR_INT_CLR) begin
            intStat_q <= (intStat_q & ~wData_q[1:0]) | intEvt;
        end else begin
            intStat_q <= intStat_q | intEvt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intEn_q <= 2'h0;
        end else if (wrLow && awAddr_q == `WDOG_ADDR_INT_EN) begin
            intEn_q <= wData_q[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(intStat_q & intEn_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign deviceResetOut = deviceReset_q;
    assign wakeUpOut = wakeUp_q;
    assign sleepModeOut = (pwr_q == WDOG_SLEEP);
    assign timeoutFlagNOut = timeoutFlagN_q;
    assign timer0TickOut = timer0Tick_q;
    assign irqOut = irq_q;
endmodule : wdog_top
`default_nettype wire

// ==== wdog_sva.sv ====
// Checker for the watchdog block: event timing seen at the top module's ports.
// Assumes a bind onto wdog_top and a strap held steady between resets.
`default_nettype none
module wdog_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clearInstrIn,
    input wire logic sleepInstrIn,
    input wire logic wakeOtherIn,
    input wire logic timer0ClkTickIn,
    input wire logic [7:0] cfgWordIn,
    input wire logic deviceResetOut,
    input wire logic wakeUpOut,
    input wire logic sleepModeOut,
    input wire logic timeoutFlagNOut,
    input wire logic timer0TickOut
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence sleepEntry;
        sleepInstrIn && !sleepModeOut && !wakeOtherIn;
    endsequence
    sequence timeoutEvent;
        deviceResetOut || wakeUpOut;
    endsequence
    // Shortest reduced period is 16 cycles, so 8 quiet cycles always hold
    sequence quiet8;
        (!deviceResetOut && !wakeUpOut) [*8];
    endsequence
    AST_EVENT_PULSE: assert property (timeoutEvent |=> !deviceResetOut && !wakeUpOut)
        else $error("time-out pulse too long");
    AST_RESET_FLAG: assert property (deviceResetOut |-> !timeoutFlagNOut && !wakeUpOut)
        else $error("reset without flag clear");
    AST_RESET_RUNNING: assert property (deviceResetOut |-> !$past(sleepModeOut))
        else $error("reset raised from sleep");
    AST_WAKE_FROM_SLEEP: assert property (
        wakeUpOut |-> $past(sleepModeOut) && !sleepModeOut && !timeoutFlagNOut)
        else $error("bad wake-up");
    AST_FLAG_CAUSE: assert property ($fell(timeoutFlagNOut) |-> timeoutEvent)
        else $error("flag cleared without time-out");
    AST_SLEEP_ENTER: assert property (sleepEntry |=> sleepModeOut)
        else $error("sleep not entered");
    AST_SLEEP_HOLDS: assert property (
        sleepModeOut && !wakeOtherIn && !$past(wakeOtherIn) |=> sleepModeOut || wakeUpOut)
        else $error("sleep left without cause");
    AST_CLEAR_QUIET: assert property (clearInstrIn |=> timeoutFlagNOut ##0 quiet8)
        else $error("time-out soon after clear");
    AST_FUSE_OFF: assert property (
        !cfgWordIn[2] |-> !deviceResetOut && !wakeUpOut && timeoutFlagNOut)
        else $error("time-out with fuse off");
    AST_TIMER_ZERO_CAUSE: assert property (timer0TickOut |-> $past(timer0ClkTickIn))
        else $error("timer zero tick without input");
endmodule : wdog_sva
bind wdog_top wdog_sva wdog_sva_i (.*);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the watchdog block: registers, time-outs, sleep, strap.
// Assumes reduced counts (tick every 2 cycles, 8-tick base) and a 100 MHz clock.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d; logic [1:0] r;} wdog_row_t;
    logic sys_clk = 1'h0, rstn = 1'h0, clearInstrIn = 1'h0, sleepInstrIn = 1'h0;
    logic wakeOtherIn = 1'h0, timer0ClkTickIn = 1'h0, s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] cfgWordIn = 8'hFF;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic deviceResetOut, wakeUpOut, sleepModeOut, timeoutFlagNOut, timer0TickOut, irqOut;
    int nErrors = 0, nChecks = 0, nRst = 0, nT0 = 0, cyc, base;
    wdog_row_t rows[14] = '{
        '{1'h0, 16'h0204, 32'h0000_00FF, 2'h0},
        '{1'h0, 16'h801C, 32'h0000_00FF, 2'h0},
        '{1'h0, 16'h0004, 32'h0000_0001, 2'h0},
        '{1'h0, 16'h000C, 32'h0000_0000, 2'h0},
        '{1'h0, 16'h0040, 32'h0000_0000, 2'h2},
        '{1'h1, 16'h0040, 32'h0000_0055, 2'h2},
        '{1'h1, 16'h801C, 32'h0000_0000, 2'h0},
        '{1'h0, 16'h801C, 32'h0000_00FF, 2'h0},
        '{1'h1, 16'h0004, 32'h0000_0000, 2'h0},
        '{1'h0, 16'h0004, 32'h0000_0001, 2'h0},
        '{1'h0, 16'h0000, 32'h0000_0000, 2'h0},
        '{1'h0, 16'h0010, 32'h0000_0000, 2'h0},
        '{1'h1, 16'h000C, 32'h0000_0003, 2'h0},
        '{1'h0, 16'h000C, 32'h0000_0003, 2'h0}};

    wdog_top #(.RcDivCyc(2), .BaseW(3)) wdog_top_i (.*);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (deviceResetOut) nRst++;
        if (timer0TickOut) nT0++;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : giveVerdict
    task automatic doReset(input logic [7:0] c);
        rstn <= 1'h0;
        cfgWordIn <= c;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'h1;
    endtask : doReset
    task automatic axw(input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 50);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 50) chk("write wait", 1, 0);
    endtask : axw
    task automatic axr(input logic [15:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 50);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 50) chk("read wait", 1, 0);
    endtask : axr
    // Core strobes are one-cycle pulses: clear, sleep, timer tick, other wake
    task automatic core(input logic c, input logic s, input logic t, input logic w);
        @(posedge sys_clk);
        {clearInstrIn, sleepInstrIn, timer0ClkTickIn, wakeOtherIn} <= {c, s, t, w};
        @(posedge sys_clk);
        {clearInstrIn, sleepInstrIn, timer0ClkTickIn, wakeOtherIn} <= 4'h0;
    endtask : core
    // Oscillator phase is free, so the period is allowed a few cycles of slack
    task automatic waitEv(input int t);
        cyc = 0;
        do begin
            @(posedge sys_clk);
            cyc++;
        end while (!deviceResetOut && !wakeUpOut && cyc < 3000);
        chk("period", 32'(cyc >= t - 6 && cyc <= t + 4), 1);
    endtask : waitEv

    initial begin
        doReset(8'hFF);
        foreach (rows[i]) begin
            if (rows[i].w) axw(rows[i].a, rows[i].d);
            else begin
                axr(rows[i].a);
                chk("rdata", rd, rows[i].d);
            end
            chk("resp", resp, rows[i].r);
        end
        // Lane 0 off: the write is answered but must leave the register alone
        s_axi_wstrb <= 4'h0;
        axw(16'h000C, 32'h0000_0000);
        s_axi_wstrb <= 4'hF;
        chk("resp", resp, 2'h0);
        axr(16'h000C);
        chk("lane off", rd, 32'h0000_0003);
        $display("register table done");
        for (int r = 0; r < 4; r++) begin
            axw(16'h0204, 32'h0000_0008 + r);
            core(1'h1, 1'h0, 1'h0, 1'h0);
            waitEv(16 * 2**r);
            chk("reset pulse", deviceResetOut, 1'h1);
            chk("flag low", timeoutFlagNOut, 1'h0);
        end
        repeat (2) @(posedge sys_clk);
        chk("irq", irqOut, 1'h1);
        axw(16'h0000, 32'h0000_0001);
        axr(16'h0204);
        chk("option kept", rd, 32'h0000_000B);
        axr(16'h0004);
        chk("flag restored", rd, 32'h0000_0001);
        axw(16'h0010, 32'h0000_0003);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", irqOut, 1'h0);
        core(1'h1, 1'h0, 1'h0, 1'h0);
        axw(16'h0204, 32'h0000_0008);
        base = nRst;
        repeat (20) begin
            core(1'h1, 1'h0, 1'h0, 1'h0);
            repeat (5) @(posedge sys_clk);
        end
        chk("kept alive", nRst, base);
        $display("time-out periods done");
        axw(16'h0204, 32'h0000_0009);
        core(1'h1, 1'h0, 1'h0, 1'h0);
        axw(16'h0010, 32'h0000_0003);
        core(1'h0, 1'h1, 1'h0, 1'h0);
        @(posedge sys_clk);
        chk("asleep", sleepModeOut, 1'h1);
        waitEv(32);
        chk("wake pulse", wakeUpOut, 1'h1);
        chk("no reset", deviceResetOut, 1'h0);
        chk("awake", sleepModeOut, 1'h0);
        chk("flag low", timeoutFlagNOut, 1'h0);
        axr(16'h0008);
        chk("wake event", rd, 32'h0000_0002);
        chk("irq", irqOut, 1'h1);
        axw(16'h000C, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", irqOut, 1'h0);
        axw(16'h0000, 32'h0000_0002);
        @(posedge sys_clk);
        chk("asleep", sleepModeOut, 1'h1);
        core(1'h0, 1'h0, 1'h0, 1'h1);
        repeat (2) @(posedge sys_clk);
        chk("other wake", sleepModeOut, 1'h0);
        $display("sleep and wake done");
        for (int k = 0; k < 3; k++) begin
            axw(16'h0204, 32'h0000_0008);
            axw(16'h0204, k < 2 ? 32'(k) : 32'h0000_0008);
            nT0 = 0;
            repeat (8) core(1'h0, 1'h0, 1'h1, 1'h0);
            repeat (3) @(posedge sys_clk);
            chk("timer zero", 32'(nT0), k < 2 ? 32'(8 >> (k + 1)) : 32'h0000_0008);
        end
        $display("timer zero done");
        doReset(8'hFB);
        axr(16'h801C);
        chk("strap", rd, 32'h0000_00FB);
        axw(16'h0204, 32'h0000_0008);
        base = nRst;
        repeat (300) @(posedge sys_clk);
        chk("fuse off", nRst, base);
        chk("flag high", timeoutFlagNOut, 1'h1);
        $display("fuse test done");
        giveVerdict();
    end
    initial begin
        // Whole run is near 1000 cycles; thirty times that means a hang
        #300us;
        chk("run time", 1, 0);
        giveVerdict();
    end
endmodule : tb_top
`default_nettype wire
